// file: verilog/mcm_pkg.sv
// Constants for the multiplexer control and monitor select register block
package mcm_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] MCM_IDX_MUX_CTRL_0 = 8'h00;
  localparam logic [7:0] MCM_IDX_BIAS = 8'h01;
  localparam logic [7:0] MCM_IDX_MUX_CTRL_1 = 8'h02;
  localparam logic [7:0] MCM_IDX_SYS_CTRL_0 = 8'h03;
  localparam logic [7:0] MCM_IDX_CONV_CTRL = 8'h10;
  localparam logic [7:0] MCM_IDX_STATUS = 8'h11;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int MCM_CLK_BIT = 7;
  localparam int MCM_VREF_LSB = 5;
  localparam int MCM_REFSEL_LSB = 3;
  localparam int MCM_MON_LSB = 0;
  localparam int MCM_GAIN_LSB = 4;
  localparam logic [7:0] MCM_INPUT_MUX_CONTROL_0_RST = 8'h01;
  localparam logic [7:0] MCM_BIAS_RST = 8'h00;
  localparam logic [6:0] MCM_INPUT_MUX_CONTROL_1_RST = 7'h00;
  localparam logic [6:0] MCM_SYSTEM_CONTROL_0_RST = 7'h00;
  localparam logic [7:0] MCM_SYSTEM_CONTROL_0_MASK = 8'h7f;
  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MCM_VREF_OFF = 2'h0;
  localparam logic [1:0] MCM_VREF_ON = 2'h1;
  localparam logic [1:0] MCM_REF_PAIR0 = 2'h0;
  localparam logic [1:0] MCM_REF_PAIR1 = 2'h1;
  localparam logic [1:0] MCM_REF_INT = 2'h2;
  localparam logic [1:0] MCM_REF_INT_PAIR0 = 2'h3;
  localparam logic [2:0] MCM_MON_NORMAL = 3'h0;
  localparam logic [2:0] MCM_MON_OFFSET = 3'h1;
  localparam logic [2:0] MCM_MON_GAIN = 3'h2;
  localparam logic [2:0] MCM_MON_TEMP = 3'h3;
  localparam logic [2:0] MCM_MON_REF1 = 3'h4;
  localparam logic [2:0] MCM_MON_REF0 = 3'h5;
  localparam logic [2:0] MCM_MON_AVDD = 3'h6;
  localparam logic [2:0] MCM_MON_DVDD = 3'h7;
  localparam logic [2:0] MCM_GAIN_UNITY = 3'h0;
  // Converter input source seen by the front end
  typedef enum logic [3:0] {
    MCM_SRC_MUX, MCM_SRC_MIDSUPPLY, MCM_SRC_VREF, MCM_SRC_TEMP,
    MCM_SRC_REF1_Q, MCM_SRC_REF0_Q, MCM_SRC_AVDD_Q, MCM_SRC_DVDD_Q
  } mcm_src_e;
endpackage

// file: verilog/mcm_mux_control.sv
// Multiplexer control register with system monitor override
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
module mcm_mux_control
  import mcm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Device state
  input wire logic ext_clk_in_use,
  input wire logic start_pin,
  input wire logic conv_active,
  input wire logic sleep_cmd,
  // Front end controls
  output logic ref_powered,
  output logic [1:0] ref_route,
  output logic ref_int_to_pair0,
  output logic [2:0] positive_input_select,
  output logic [2:0] negative_input_select,
  output logic [7:0] bias_voltage_enables,
  output logic inputs_disconnected,
  output logic [3:0] conv_input_source,
  output logic [2:0] gain_amplifier
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] clk_sync;
  logic [1:0] start_sync;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_sync <= 2'h0;
      start_sync <= 2'h0;
    end else begin
      clk_sync <= {clk_sync[0], ext_clk_in_use};
      start_sync <= {start_sync[0], start_pin};
    end
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic req;
  logic hit;
  logic wr;
  logic [7:0] idx;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign idx = {2'h0, wb_adr_i[7:2]};
  assign hit = wb_adr_i[1:0] == 2'h0 &&
               (idx == MCM_IDX_MUX_CTRL_0 || idx == MCM_IDX_BIAS ||
                idx == MCM_IDX_MUX_CTRL_1 || idx == MCM_IDX_SYS_CTRL_0 ||
                idx == MCM_IDX_CONV_CTRL || idx == MCM_IDX_STATUS);
  assign wr = req & hit & wb_we_i & wb_sel_i[0];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] mux_ctrl_0;
  logic [7:0] bias_reg;
  logic [6:0] input_mux_control_1;
  logic [6:0] sys_ctrl_0;
  logic conv_sw;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mux_ctrl_0 <= MCM_INPUT_MUX_CONTROL_0_RST;
      bias_reg <= MCM_BIAS_RST;
      input_mux_control_1 <= MCM_INPUT_MUX_CONTROL_1_RST;
      sys_ctrl_0 <= MCM_SYSTEM_CONTROL_0_RST;
      conv_sw <= 1'b0;
    end else if (wr) begin
      case (idx)
        MCM_IDX_MUX_CTRL_0: mux_ctrl_0 <= wb_dat_i[7:0];
        MCM_IDX_BIAS: bias_reg <= wb_dat_i[7:0];
        MCM_IDX_MUX_CTRL_1: input_mux_control_1 <= wb_dat_i[6:0];
        MCM_IDX_SYS_CTRL_0: sys_ctrl_0 <= wb_dat_i[6:0];
        MCM_IDX_CONV_CTRL: conv_sw <= wb_dat_i[0];
        default: conv_sw <= conv_sw;
      endcase
    end
  end

  logic [1:0] internal_ref_power_ctrl;
  logic [1:0] ref_input_select;
  logic [2:0] monitor_select;
  assign internal_ref_power_ctrl = input_mux_control_1[MCM_VREF_LSB +: 2];
  assign ref_input_select = input_mux_control_1[MCM_REFSEL_LSB +: 2];
  assign monitor_select = input_mux_control_1[MCM_MON_LSB +: 3];

  // ----------------------------------------------------------------
  // Read data and acknowledge
  // ----------------------------------------------------------------
  logic [7:0] rd;
  logic clock_source_flag;
  assign clock_source_flag = clk_sync[1];
  always_comb begin
    case (idx)
      MCM_IDX_MUX_CTRL_0: rd = mux_ctrl_0;
      MCM_IDX_BIAS: rd = bias_reg;
      MCM_IDX_MUX_CTRL_1: rd = {clock_source_flag, input_mux_control_1};
      MCM_IDX_SYS_CTRL_0: rd = {1'b0, sys_ctrl_0} & MCM_SYSTEM_CONTROL_0_MASK;
      MCM_IDX_CONV_CTRL: rd = {7'h00, conv_sw};
      MCM_IDX_STATUS: rd = {5'h00, inputs_disconnected, ref_powered,
                            conv_active};
      default: rd = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req & hit;
      wb_err_o <= req & ~hit;
      wb_dat_o <= (req & hit & ~wb_we_i) ? {24'h0, rd} : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Internal reference power
  // ----------------------------------------------------------------
  logic follow_on;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      follow_on <= 1'b0;
    end else if (sleep_cmd || !start_sync[1]) begin
      follow_on <= 1'b0;
    end else if (conv_active || conv_sw) begin
      follow_on <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_powered <= 1'b0;
    end else begin
      case (internal_ref_power_ctrl)
        MCM_VREF_OFF: ref_powered <= 1'b0;
        MCM_VREF_ON: ref_powered <= 1'b1;
        default: ref_powered <= follow_on;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Routing with monitor override
  // ----------------------------------------------------------------
  logic mon_active;
  assign mon_active = monitor_select != MCM_MON_NORMAL;

  function automatic logic [3:0] mon_source(input logic [2:0] code);
    case (code)
      MCM_MON_OFFSET: mon_source = 4'(MCM_SRC_MIDSUPPLY);
      MCM_MON_GAIN: mon_source = 4'(MCM_SRC_VREF);
      MCM_MON_TEMP: mon_source = 4'(MCM_SRC_TEMP);
      MCM_MON_REF1: mon_source = 4'(MCM_SRC_REF1_Q);
      MCM_MON_REF0: mon_source = 4'(MCM_SRC_REF0_Q);
      MCM_MON_AVDD: mon_source = 4'(MCM_SRC_AVDD_Q);
      MCM_MON_DVDD: mon_source = 4'(MCM_SRC_DVDD_Q);
      default: mon_source = 4'(MCM_SRC_MUX);
    endcase
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_route <= MCM_REF_PAIR0;
      ref_int_to_pair0 <= 1'b0;
      positive_input_select <= 3'h0;
      negative_input_select <= 3'h1;
      bias_voltage_enables <= 8'h00;
      inputs_disconnected <= 1'b0;
      conv_input_source <= 4'(MCM_SRC_MUX);
      gain_amplifier <= MCM_GAIN_UNITY;
    end else begin
      conv_input_source <= mon_source(monitor_select);
      inputs_disconnected <= mon_active;
      positive_input_select <= mux_ctrl_0[5:3];
      negative_input_select <= mux_ctrl_0[2:0];
      bias_voltage_enables <= mon_active ? 8'h00 : bias_reg;
      if (mon_active) begin
        ref_route <= MCM_REF_PAIR0;
        ref_int_to_pair0 <= 1'b0;
      end else begin
        ref_route <= (ref_input_select == MCM_REF_INT_PAIR0) ?
                     MCM_REF_INT : ref_input_select;
        ref_int_to_pair0 <= ref_input_select == MCM_REF_INT_PAIR0;
      end
      if (monitor_select == MCM_MON_NORMAL ||
          monitor_select == MCM_MON_OFFSET) begin
        gain_amplifier <= sys_ctrl_0[MCM_GAIN_LSB +: 3];
      end else begin
        gain_amplifier <= MCM_GAIN_UNITY;
      end
    end
  end
endmodule

// file: tb/mcm_mux_control_sva.sv
// Assertions for the multiplexer control and monitor select block
`timescale 1ns/1ps
module mcm_mux_control_sva
  import mcm_pkg::*;
(
  // Clock, reset and bus
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic sleep_cmd,
  // Front end controls
  input wire logic ref_powered,
  input wire logic [1:0] ref_route,
  input wire logic ref_int_to_pair0,
  input wire logic [7:0] bias_voltage_enables,
  input wire logic inputs_disconnected,
  input wire logic [3:0] conv_input_source,
  input wire logic [2:0] gain_amplifier
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Copy of control 1, settled when st is high
  // ----------------------------------------
  logic [7:0] sh;
  logic [7:0] sh_d;
  logic st;
  assign st = (sh == sh_d);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh <= 8'h00;
      sh_d <= 8'h00;
    end else begin
      if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h08) begin
        sh <= wb_dat_i[7:0];
      end
      sh_d <= sh;
    end
  end
  a_ref_off_mode:
    assert property (st && sh[6:5] == 2'h0 |-> !ref_powered)
    else $error("Reference on in off mode");
  a_ref_on_mode:
    assert property (st && sh[6:5] == 2'h1 |-> ref_powered)
    else $error("Reference off in on mode");
  a_ref_sleep_off:
    assert property (st && sh[6] && sleep_cmd |-> ##[1:2] !ref_powered)
    else $error("Reference stays on after power-down");
  a_ref_route_sel:
    assert property (st && sh[2:0] == 3'h0 |->
      ref_route == (sh[4:3] == 2'h3 ? 2'h2 : sh[4:3]))
    else $error("Reference route wrong");
  a_ref_pair_drive:
    assert property (st && sh[2:0] == 3'h0 |->
      ref_int_to_pair0 == (sh[4:3] == 2'h3))
    else $error("Internal reference on pair 0 wrong");
  a_mon_override:
    assert property (st && sh[2:0] != 3'h0 |->
      ref_route == 2'h0 && bias_voltage_enables == 8'h00)
    else $error("Monitor does not override");
  a_mon_source:
    assert property (st |-> conv_input_source == {1'b0, sh[2:0]})
    else $error("Converter input source wrong");
  a_mon_disconnect:
    assert property (st |-> inputs_disconnected == (sh[2:0] != 3'h0))
    else $error("Input disconnect flag wrong");
  a_gain_forced:
    assert property (st && sh[2:1] != 2'h0 |-> gain_amplifier == 3'h0)
    else $error("Gain not forced to unity");
  cover property (st && sh[2:0] == 3'h7);
  cover property (st && sh[4:3] == 2'h3);
  cover property (st && sh[6] && sleep_cmd);
endmodule

bind mcm_mux_control mcm_mux_control_sva chk (.clk(clk), .rst(rst),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .sleep_cmd(sleep_cmd),
  .ref_powered(ref_powered), .ref_route(ref_route),
  .ref_int_to_pair0(ref_int_to_pair0),
  .bias_voltage_enables(bias_voltage_enables),
  .inputs_disconnected(inputs_disconnected),
  .conv_input_source(conv_input_source), .gain_amplifier(gain_amplifier));

// file: tb/test_mux_control_monitor_select.sv
// Self-checking bench for the multiplexer control and monitor block
`timescale 1ns/1ps
module test_mux_control_monitor_select
  import mcm_pkg::*;
;
  logic clk, rst, cyc, stb, we, ack, err, ext, stp, conv, slp, rp, rip;
  logic disc, e;
  logic [1:0] rr;
  logic [2:0] ps, ns, gain;
  logic [3:0] sel, src;
  logic [7:0] adr, bias, q;
  logic [31:0] dati, dato;
  int n_fail = 0;
  int check_count = 0;
  mcm_mux_control dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dati), .wb_dat_o(dato), .wb_ack_o(ack), .wb_err_o(err),
    .ext_clk_in_use(ext), .start_pin(stp), .conv_active(conv),
    .sleep_cmd(slp), .ref_powered(rp), .ref_route(rr),
    .ref_int_to_pair0(rip), .positive_input_select(ps),
    .negative_input_select(ns), .bias_voltage_enables(bias),
    .inputs_disconnected(disc), .conv_input_source(src),
    .gain_amplifier(gain));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dati <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
    q = dato[7:0];
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    check_count++;
    if (g !== x) begin
      n_fail++;
      $display("FAIL %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_clock_flag();
    bus(1'b0, 8'h08, 8'h00);
    chk(q, 8'h00);
    ext <= 1'b1;
    tick(4);
    bus(1'b1, 8'h08, 8'h00);
    bus(1'b0, 8'h08, 8'h00);
    chk(q, 8'h80);
    ext <= 1'b0;
    tick(4);
    bus(1'b1, 8'h08, 8'h80);
    bus(1'b0, 8'h08, 8'h00);
    chk(q, 8'h00);
    bus(1'b0, 8'h20, 8'h00);
    chk(e, 8'h01);
  endtask
  task automatic t_monitor();
    logic [2:0] c;
    bus(1'b1, 8'h0c, 8'h50);
    bus(1'b1, 8'h04, 8'ha5);
    bus(1'b1, 8'h00, 8'h1a);
    tick(2);
    chk(ps, 8'h03);
    chk(ns, 8'h02);
    for (int m = 0; m < 9; m++) begin
      c = (m == 8) ? 3'h1 : 3'(m);
      bus(1'b1, 8'h08, {3'h1, 2'h0, c});
      tick(2);
      chk(src, {5'h0, c});
      chk(gain, c < 3'h2 ? 8'h05 : {5'h0, MCM_GAIN_UNITY});
      chk(bias, c == 3'h0 ? 8'ha5 : 8'h00);
      chk(disc, c != 3'h0);
    end
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, 8'h08, {3'h0, 2'(r), 3'h0});
      tick(2);
      chk(rr, r == 3 ? 8'h02 : 8'(r));
      chk(rip, r == 3);
    end
  endtask
  task automatic t_ref_power();
    bus(1'b1, 8'h08, 8'h20);
    tick(2);
    chk(rp, 8'h01);
    bus(1'b0, 8'h44, 8'h00);
    chk(q, 8'h02);
    for (int v = 2; v < 4; v++) begin
      bus(1'b1, 8'h08, {1'b0, 2'(v), 5'h0});
      conv <= 1'b1;
      tick(3);
      chk(rp, 8'h01);
      conv <= 1'b0;
      slp <= 1'b1;
      tick(1);
      slp <= 1'b0;
      tick(3);
      chk(rp, 8'h00);
      conv <= 1'b1;
      tick(1);
      conv <= 1'b0;
      stp <= 1'b0;
      tick(6);
      chk(rp, 8'h00);
      stp <= 1'b1;
      tick(4);
    end
    bus(1'b1, 8'h08, 8'h40);
    bus(1'b1, 8'h40, 8'h01);
    tick(2);
    chk(rp, 8'h01);
    bus(1'b1, 8'h40, 8'h00);
    slp <= 1'b1;
    tick(1);
    slp <= 1'b0;
    tick(3);
    chk(rp, 8'h00);
    bus(1'b1, 8'h08, 8'h00);
    tick(2);
    chk(rp, 8'h00);
  endtask
  initial begin
    {rst, stp} = 2'h3;
    {cyc, stb, we, ext, conv, slp} = 6'h0;
    {adr, sel, dati} = {8'h00, 4'h1, 32'h0};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_clock_flag();
    t_monitor();
    t_ref_power();
    final_report();
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    final_report();
  end
endmodule
